/* bench/ecsd_checker.sv */
`timescale 1ns/1ps
// ==========
// Decoder port checker
module ecsd_checker (
	// Clock, reset and mode
	input logic                clk,
	input logic                rst,
	input logic                expandedMode,
	// Configuration
	input logic                regWrite,
	input ecsd_pkg::ecsd_reg_t regSel,
	input logic [7:0]          regWdata,
	input logic [7:0]          stretchRegOut,
	input logic [7:0]          controlRegOut,
	input logic [7:0]          sizeRegOut,
	// CPU bus
	input logic [15:0]         addr,
	input logic                addrValid,
	input logic                eTick,
	input logic [3:0]          regBlockBase,
	// Selects and stretch
	input logic                ioSelectOne,
	input logic                ioSelectTwo,
	input logic                programSelect,
	input logic                generalSelect,
	input logic                eStretch
);
	import ecsd_pkg::*;

	logic prevValid_r;
	logic cycStart;

	always_ff @(posedge clk) begin
		prevValid_r <= addrValid;
	end
	assign cycStart = addrValid && !prevValid_r;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Program cycle start with a two E tick stretch and nothing competing
	sequence sProgStart;
		cycStart && controlRegOut[7:2] == 6'h01 && addr >= 16'hE000
			&& stretchRegOut[1:0] == 2'h2;
	endsequence
	chk_reset_state: assert property (disable iff (1'b0) rst |=>
		{ioSelectOne, ioSelectTwo, programSelect, generalSelect} == 4'hF
		&& !eStretch && sizeRegOut == 8'h07
		&& controlRegOut == {5'h00, $past(expandedMode), 2'h0}
		&& stretchRegOut == {7'h00, $past(expandedMode)})
		else $error("reset state wrong");
	chk_ctl_write: assert property (
		regWrite && regSel == ECSD_REG_CONTROL
		|=> controlRegOut == $past(regWdata))
		else $error("control write lost");
	chk_io_one_off: assert property (!controlRegOut[7]
		|=> ioSelectOne == !$past(controlRegOut[6])) else $error("io one on");
	chk_io_two_hit: assert property (controlRegOut[5] && sizeRegOut[6]
		&& addrValid && addr[15:11] == {regBlockBase, 1'b1}
		|=> ioSelectTwo == $past(controlRegOut[4])) else $error("io two off");
	chk_prog_range: assert property (controlRegOut[1:0] == 2'h3
		&& addr < 16'hE000 |=> programSelect) else $error("program range");
	chk_prog_idle: assert property (!addrValid |=> programSelect)
		else $error("program without address");
	chk_gen_off: assert property (sizeRegOut[2:0] == 3'h7
		|=> generalSelect == !$past(sizeRegOut[4])) else $error("general on");
	chk_stretch_go: assert property (sProgStart |=> eStretch)
		else $error("stretch missing");
	chk_io_stretch: assert property (cycStart && controlRegOut[7]
		&& addr[15:11] == {regBlockBase, 1'b0} && addr[10:0] >= 11'h060
		&& stretchRegOut[7:6] != 2'h0 |=> eStretch)
		else $error("io stretch missing");
	chk_stretch_idle: assert property (!eStretch && !cycStart
		|=> !eStretch) else $error("stretch outside cycle");
	chk_stretch_hold: assert property (eStretch && !eTick && !cycStart
		|=> eStretch) else $error("stretch dropped early");
endmodule : ecsd_checker

bind ecsd_decoder ecsd_checker chk (.clk(clk), .rst(rst),
	.expandedMode(expandedMode), .regWrite(regWrite), .regSel(regSel),
	.regWdata(regWdata), .stretchRegOut(stretchRegOut),
	.controlRegOut(controlRegOut), .sizeRegOut(sizeRegOut), .addr(addr),
	.addrValid(addrValid), .eTick(eTick), .regBlockBase(regBlockBase),
	.ioSelectOne(ioSelectOne), .ioSelectTwo(ioSelectTwo),
	.programSelect(programSelect), .generalSelect(generalSelect),
	.eStretch(eStretch));

/* bench/ecsd_ext_device.sv */
`timescale 1ns/1ps
// ==========
// External memory on the program select
module ecsd_ext_device (
	// Clock and reset
	input logic        clk,
	input logic        rst,
	// Decoder outputs
	input logic        programSelect,
	input logic        eStretch,
	// Accesses served
	output logic [7:0] hitCount
);
	// Counts selected cycles that are not held by a stretch
	always_ff @(posedge clk) begin
		if (rst)
			hitCount <= 8'h00;
		else if (!programSelect && !eStretch)
			hitCount <= hitCount + 8'h01;
	end
endmodule : ecsd_ext_device

/* bench/tb_ecsd_decoder.sv */
`timescale 1ns/1ps
// ==========
// Decoder bench
module tb_ecsd_decoder;
	import ecsd_pkg::*;
	logic clk = 0, rst = 1, expandedMode = 1, regWrite = 0;
	logic addrValid = 0, eHigh = 0, eTick = 0;
	ecsd_reg_t regSel = ECSD_REG_STRETCH;
	logic [7:0] regWdata = 8'h00, stretchRegOut, controlRegOut;
	logic [7:0] baseRegOut, sizeRegOut, hitCount;
	logic [15:0] addr = 16'h0000;
	logic [3:0] regBlockBase = 4'h1;
	logic ioSelectOne, ioSelectTwo, programSelect, generalSelect, eStretch;
	logic [15:0] lo [4] = '{16'h0000, 16'h8000, 16'hC000, 16'hE000};
	logic [15:0] ioA [5] = '{16'h105F, 16'h1060, 16'h17FF, 16'h1800,
		16'h2060};
	logic [3:0] ioE [5] = '{4'h7, 4'hF, 4'hF, 4'h7, 4'h7};
	int n_errors = 0, n_tests = 0;
	always #20 clk = ~clk;
	ecsd_decoder uut (.clk(clk), .rst(rst), .expandedMode(expandedMode),
		.regWrite(regWrite), .regSel(regSel), .regWdata(regWdata),
		.stretchRegOut(stretchRegOut), .controlRegOut(controlRegOut),
		.baseRegOut(baseRegOut), .sizeRegOut(sizeRegOut), .addr(addr),
		.addrValid(addrValid), .eHigh(eHigh), .eTick(eTick),
		.regBlockBase(regBlockBase), .ioSelectOne(ioSelectOne),
		.ioSelectTwo(ioSelectTwo), .programSelect(programSelect),
		.generalSelect(generalSelect), .eStretch(eStretch));
	ecsd_ext_device mem (.clk(clk), .rst(rst), .programSelect(programSelect),
		.eStretch(eStretch), .hitCount(hitCount));
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic sel(input logic [3:0] e);
		cmp({4'h0, ioSelectOne, ioSelectTwo, programSelect, generalSelect},
			{4'h0, e});
	endtask : sel
	task automatic wr(input ecsd_reg_t s, input logic [7:0] d);
		@(posedge clk) #1;
		regWrite = 1;
		regSel = s;
		regWdata = d;
		@(posedge clk) #1;
		regWrite = 0;
	endtask : wr
	task automatic bus(input logic [15:0] a, input logic v, input logic e);
		addr = a;
		addrValid = v;
		eHigh = e;
		@(posedge clk) #1;
	endtask : bus
	task automatic tick;
		eTick = 1;
		@(posedge clk) #1;
		eTick = 0;
	endtask : tick
	task automatic doReset(input logic m);
		expandedMode = m;
		rst = 1;
		repeat (5) @(posedge clk);
		#1 rst = 0;
	endtask : doReset
	task automatic end_of_test;
		if (n_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test
	initial begin
		doReset(1);
		cmp(stretchRegOut, 8'h01);
		cmp(controlRegOut, 8'h04);
		cmp(sizeRegOut, 8'h07);
		sel(4'hF);
		for (int c = 0; c < 4; c++) begin
			wr(ECSD_REG_CONTROL, 8'h04 | 8'(c));
			bus(lo[c], 1, 0);
			sel(4'hD);
			bus(lo[c] - 16'h0001, 1, 0);
			if (c > 0)
				sel(4'hF);
		end
		bus(16'hE000, 0, 1);
		sel(4'hF);
		wr(ECSD_REG_CONTROL, 8'h03);
		bus(16'hF000, 1, 0);
		sel(4'hF);
		wr(ECSD_REG_BASE, 8'hFF);
		cmp(baseRegOut, 8'hFC);
		wr(ECSD_REG_SIZE, 8'hFF);
		cmp(sizeRegOut, 8'hDF);
		wr(ECSD_REG_CONTROL, 8'hC0);
		wr(ECSD_REG_SIZE, 8'h87);
		for (int i = 0; i < 5; i++) begin
			bus(ioA[i], 1, 0);
			sel(ioE[i]);
		end
		// Moving the register page moves the I/O window with it
		regBlockBase = 4'h2;
		bus(16'h2060, 1, 0);
		sel(4'hF);
		regBlockBase = 4'h1;
		wr(ECSD_REG_SIZE, 8'h07);
		bus(16'h1060, 1, 0);
		sel(4'h7);
		bus(16'h1060, 1, 1);
		sel(4'hF);
		wr(ECSD_REG_CONTROL, 8'h40);
		bus(16'h1060, 1, 1);
		sel(4'h7);
		wr(ECSD_REG_CONTROL, 8'h20);
		wr(ECSD_REG_SIZE, 8'h47);
		bus(16'h1800, 1, 0);
		sel(4'hB);
		wr(ECSD_REG_BASE, 8'h5C);
		wr(ECSD_REG_SIZE, 8'h1C);
		wr(ECSD_REG_CONTROL, 8'h04);
		bus(16'h5000, 1, 0);
		sel(4'hC);
		wr(ECSD_REG_CONTROL, 8'h0C);
		bus(16'h5FFF, 1, 0);
		sel(4'hF);
		bus(16'h6000, 1, 0);
		sel(4'hC);
		bus(16'h4FFF, 1, 0);
		sel(4'hC);
		wr(ECSD_REG_CONTROL, 8'h00);
		wr(ECSD_REG_SIZE, 8'h14);
		bus(16'h5000, 1, 0);
		sel(4'hE);
		bus(16'h5000, 1, 1);
		sel(4'hF);
		wr(ECSD_REG_SIZE, 8'h1F);
		bus(16'h5000, 1, 1);
		sel(4'hE);
		wr(ECSD_REG_SIZE, 8'h07);
		wr(ECSD_REG_STRETCH, 8'h02);
		wr(ECSD_REG_CONTROL, 8'h04);
		bus(16'h0000, 0, 0);
		bus(16'hF000, 1, 0);
		cmp({7'h00, eStretch}, 8'h01);
		tick();
		@(posedge clk) #1;
		cmp({7'h00, eStretch}, 8'h01);
		tick();
		cmp({7'h00, eStretch}, 8'h00);
		wr(ECSD_REG_STRETCH, 8'h00);
		bus(16'h0000, 0, 0);
		bus(16'hF000, 1, 0);
		cmp({7'h00, eStretch}, 8'h00);
		cmp({7'h00, hitCount != 8'h00}, 8'h01);
		// E-timed I/O select still stretches although E is low at start
		wr(ECSD_REG_STRETCH, 8'h80);
		wr(ECSD_REG_CONTROL, 8'hC0);
		bus(16'h0000, 0, 0);
		bus(16'h1060, 1, 0);
		cmp({7'h00, eStretch}, 8'h01);
		sel(4'h7);
		tick();
		cmp({7'h00, eStretch}, 8'h01);
		@(posedge clk) #1;
		tick();
		cmp({7'h00, eStretch}, 8'h00);
		bus(16'h0000, 0, 0);
		doReset(0);
		cmp(controlRegOut, 8'h00);
		cmp(stretchRegOut, 8'h00);
		bus(16'hF000, 1, 0);
		sel(4'hF);
		end_of_test();
	end
endmodule : tb_ecsd_decoder

/* core/ecsd_decoder.sv */
`timescale 1ns/1ps
module ecsd_decoder (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// Operating mode, sampled while reset is high
	input  wire logic               expandedMode,
	// Configuration write port
	input  wire logic               regWrite,
	input  wire ecsd_pkg::ecsd_reg_t regSel,
	input  wire logic [7:0]         regWdata,
	// Configuration read back
	output logic [7:0]              stretchRegOut,
	output logic [7:0]              controlRegOut,
	output logic [7:0]              baseRegOut,
	output logic [7:0]              sizeRegOut,
	// CPU bus
	input  wire logic [15:0]        addr,
	input  wire logic               addrValid,
	input  wire logic               eHigh,
	input  wire logic               eTick,
	input  wire logic [3:0]         regBlockBase,
	// Chip selects
	output logic                    ioSelectOne,
	output logic                    ioSelectTwo,
	output logic                    programSelect,
	output logic                    generalSelect,
	// E clock high phase hold
	output logic                    eStretch
);
	import ecsd_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic [7:0] stretch_r;
		logic [7:0] control_r;
		logic [7:0] base_r;
		logic [7:0] size_r;
		logic       ioOne_r;
		logic       ioTwo_r;
		logic       prog_r;
		logic       gen_r;
		logic       validPrev_r;
	} ecsd_state_t;

	ecsd_state_t st_r;
	ecsd_state_t st_nxt;

	// ==========================================================
	// Field views
	logic       ioOneEnable;
	logic       ioTwoEnable;
	logic       ioOnePolarity;
	logic       ioTwoPolarity;
	logic       priorityGeneral;
	logic       programSelectEnable;
	logic [1:0] programSize;
	logic       ioOneAddrValid;
	logic       ioTwoAddrValid;
	logic       generalPolarity;
	logic       generalAddrValid;
	logic [2:0] generalSize;
	logic [5:0] generalBase;
	logic [1:0] ioOneStretch;
	logic [1:0] ioTwoStretch;
	logic [1:0] generalStretch;
	logic [1:0] programStretch;

	assign ioOneEnable         = st_r.control_r[CTL_IO_ONE_EN];
	assign ioTwoEnable         = st_r.control_r[CTL_IO_TWO_EN];
	assign ioOnePolarity       = st_r.control_r[CTL_IO_ONE_POL];
	assign ioTwoPolarity       = st_r.control_r[CTL_IO_TWO_POL];
	assign priorityGeneral     = st_r.control_r[CTL_GEN_PRIO];
	assign programSelectEnable = st_r.control_r[CTL_PROG_EN];
	assign programSize     = st_r.control_r[CTL_PROG_SIZE +: 2];
	assign ioOneAddrValid      = st_r.size_r[SIZ_IO_ONE_AV];
	assign ioTwoAddrValid      = st_r.size_r[SIZ_IO_TWO_AV];
	assign generalPolarity     = st_r.size_r[SIZ_GEN_POL];
	assign generalAddrValid    = st_r.size_r[SIZ_GEN_AV];
	assign generalSize         = st_r.size_r[SIZ_GEN_SIZE +: 3];
	assign generalBase         = st_r.base_r[7:2];
	assign ioOneStretch        = st_r.stretch_r[STR_IO_ONE +: 2];
	assign ioTwoStretch        = st_r.stretch_r[STR_IO_TWO +: 2];
	assign generalStretch      = st_r.stretch_r[STR_GEN +: 2];
	assign programStretch      = st_r.stretch_r[STR_PROG +: 2];

	// ==========================================================
	// Range decode
	logic hitIoOne;
	logic hitIoTwo;
	logic hitProg;
	logic hitGen;

	ecsd_gen_match u_gen_match (
		.addr    (addr),
		.genBase (generalBase),
		.genSize (generalSize),
		.genHit  (hitGen)
	);

	always_comb begin
		hitIoOne = (addr[15:12] == regBlockBase) &&
			!addr[11] && (addr[11:0] >= IO_ONE_LOW);
		hitIoTwo = (addr[15:12] == regBlockBase) && addr[11];
		case (programSize)
			PROG_64K: hitProg = 1'b1;
			PROG_32K: hitProg = addr[15];
			PROG_16K: hitProg = (addr[15:14] == 2'h3);
			default:  hitProg = (addr[15:13] == 3'h7);
		endcase
	end

	// ==========================================================
	// Qualification and priority
	logic actIoOne;
	logic actIoTwo;
	logic actProg;
	logic actGen;
	logic bothHit;

	always_comb begin
		actIoOne = ioOneEnable && hitIoOne && addrValid &&
			(ioOneAddrValid || eHigh);
		actIoTwo = ioTwoEnable && hitIoTwo && addrValid &&
			(ioTwoAddrValid || eHigh);
		bothHit  = hitGen && programSelectEnable && hitProg;
		actGen   = hitGen && addrValid &&
			(generalAddrValid || eHigh) &&
			(!bothHit || priorityGeneral);
		actProg  = programSelectEnable && hitProg && addrValid &&
			!(bothHit && priorityGeneral);
	end

	// ==========================================================
	// Stretch of the active cycle
	logic       cycleStart;
	logic [1:0] stretchCount;
	logic       stretchBusy;

	always_comb begin
		cycleStart = addrValid && !st_r.validPrev_r;
		// An E-timed select asserts later in the cycle, so pick on hit
		if (ioOneEnable && hitIoOne) begin
			stretchCount = ioOneStretch;
		end else if (ioTwoEnable && hitIoTwo) begin
			stretchCount = ioTwoStretch;
		end else if (hitGen && (!bothHit || priorityGeneral)) begin
			stretchCount = generalStretch;
		end else if (actProg) begin
			stretchCount = programStretch;
		end else begin
			stretchCount = 2'h0;
		end
	end

	ecsd_stretch_timer u_stretch (
		.clk   (clk),
		.rst   (rst),
		.start (cycleStart),
		.count (stretchCount),
		.eTick (eTick),
		.busy  (stretchBusy)
	);

	assign eStretch = stretchBusy;

	// ==========================================================
	// Next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.validPrev_r = addrValid;
		if (regWrite) begin
			case (regSel)
				ECSD_REG_STRETCH: st_nxt.stretch_r = regWdata;
				ECSD_REG_CONTROL: st_nxt.control_r = regWdata;
				ECSD_REG_BASE:
					st_nxt.base_r = regWdata & BASE_USED_MASK;
				ECSD_REG_SIZE:
					st_nxt.size_r = regWdata & SIZE_USED_MASK;
				default: st_nxt.stretch_r = st_r.stretch_r;
			endcase
		end
		st_nxt.ioOne_r = ecsdLevel(actIoOne, ioOnePolarity);
		st_nxt.ioTwo_r = ecsdLevel(actIoTwo, ioTwoPolarity);
		st_nxt.prog_r  = ecsdLevel(actProg, 1'b0);
		st_nxt.gen_r   = ecsdLevel(actGen, generalPolarity);
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r.stretch_r   <= expandedMode ? STRETCH_RST_EXP
				: STRETCH_RST_SINGLE;
			st_r.control_r   <= expandedMode ? CONTROL_RST_EXP
				: CONTROL_RST_SINGLE;
			st_r.base_r      <= BASE_RST;
			st_r.size_r      <= SIZE_RST;
			st_r.ioOne_r     <= 1'b1;
			st_r.ioTwo_r     <= 1'b1;
			st_r.prog_r      <= 1'b1;
			st_r.gen_r       <= 1'b1;
			st_r.validPrev_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign stretchRegOut = st_r.stretch_r;
	assign controlRegOut = st_r.control_r;
	assign baseRegOut    = st_r.base_r;
	assign sizeRegOut    = st_r.size_r;
	assign ioSelectOne   = st_r.ioOne_r;
	assign ioSelectTwo   = st_r.ioTwo_r;
	assign programSelect = st_r.prog_r;
	assign generalSelect = st_r.gen_r;

endmodule : ecsd_decoder

/* core/ecsd_gen_match.sv */
`timescale 1ns/1ps
module ecsd_gen_match (
	// Address and programmed range
	input  wire logic [15:0] addr,
	input  wire logic [5:0]  genBase,
	input  wire logic [2:0]  genSize,
	// Range hit
	output logic             genHit
);
	import ecsd_pkg::*;

	logic [5:0] cmpMask;

	// Code n compares the top n base bits; 64K compares none
	always_comb begin
		cmpMask = 6'h3F << (3'h6 - genSize);
		if (genSize == 3'h0) begin
			cmpMask = 6'h00;
		end
		genHit = (genSize != GEN_SIZE_OFF) &&
			(((addr[15:10] ^ genBase) & cmpMask) == 6'h00);
	end

endmodule : ecsd_gen_match

/* core/ecsd_pkg.sv */
package ecsd_pkg;

	// Register indices on the configuration write port
	typedef enum logic [1:0] {
		ECSD_REG_STRETCH,
		ECSD_REG_CONTROL,
		ECSD_REG_BASE,
		ECSD_REG_SIZE
	} ecsd_reg_t;

	// Stretch register fields
	localparam int STR_IO_ONE  = 6;
	localparam int STR_IO_TWO  = 4;
	localparam int STR_GEN     = 2;
	localparam int STR_PROG    = 0;

	// Control register fields
	localparam int CTL_IO_ONE_EN  = 7;
	localparam int CTL_IO_ONE_POL = 6;
	localparam int CTL_IO_TWO_EN  = 5;
	localparam int CTL_IO_TWO_POL = 4;
	localparam int CTL_GEN_PRIO   = 3;
	localparam int CTL_PROG_EN    = 2;
	localparam int CTL_PROG_SIZE  = 0;

	// Size register fields
	localparam int SIZ_IO_ONE_AV = 7;
	localparam int SIZ_IO_TWO_AV = 6;
	localparam int SIZ_GEN_POL   = 4;
	localparam int SIZ_GEN_AV    = 3;
	localparam int SIZ_GEN_SIZE  = 0;

	// Reset values and write masks
	localparam logic [7:0] STRETCH_RST_SINGLE = 8'h00;
	localparam logic [7:0] STRETCH_RST_EXP    = 8'h01;
	localparam logic [7:0] CONTROL_RST_SINGLE = 8'h00;
	localparam logic [7:0] CONTROL_RST_EXP    = 8'h04;
	localparam logic [7:0] BASE_RST           = 8'h00;
	localparam logic [7:0] SIZE_RST           = 8'h07;
	localparam logic [7:0] BASE_USED_MASK     = 8'hFC;
	localparam logic [7:0] SIZE_USED_MASK     = 8'hDF;

	// Address decode constants
	localparam logic [11:0] IO_ONE_LOW   = 12'h060;
	localparam logic [2:0]  GEN_SIZE_OFF = 3'h7;
	localparam logic [1:0]  PROG_64K     = 2'h0;
	localparam logic [1:0]  PROG_32K     = 2'h1;
	localparam logic [1:0]  PROG_16K     = 2'h2;

	// Drive a select at its asserted or inactive level
	function automatic logic ecsdLevel(input logic active,
		input logic activeHigh);
		ecsdLevel = activeHigh ? active : ~active;
	endfunction : ecsdLevel

endpackage : ecsd_pkg

/* core/ecsd_stretch_timer.sv */
`timescale 1ns/1ps
module ecsd_stretch_timer (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Request
	input  wire logic       start,
	input  wire logic [1:0] count,
	input  wire logic       eTick,
	// Hold of E high phase
	output logic            busy
);
	import ecsd_pkg::*;

	typedef struct packed {
		logic [1:0] left_r;
	} ecsd_str_state_t;

	ecsd_str_state_t st_r;
	ecsd_str_state_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (start) begin
			st_nxt.left_r = count;
		end else if (eTick && st_r.left_r != 2'h0) begin
			st_nxt.left_r = st_r.left_r - 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign busy = (st_r.left_r != 2'h0);

endmodule : ecsd_stretch_timer
